// ==== verilog/css_scheduler.sv ====
// Conversion scheduler with configuration registers
`timescale 1ns/1ps
module css_scheduler #(
  parameter int RAW_W = 11,
  parameter int unsigned INTERVAL_SHORT_CYC = css_pkg::CSS_INTERVAL_SHORT_US * css_pkg::CSS_CLK_MHZ,
  parameter int unsigned INTERVAL_MID_CYC = css_pkg::CSS_INTERVAL_MID_US * css_pkg::CSS_CLK_MHZ,
  parameter int unsigned INTERVAL_LONG_CYC = css_pkg::CSS_INTERVAL_LONG_US * css_pkg::CSS_CLK_MHZ
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic conv_start,
  output logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic signed [RAW_W-1:0] conv_raw,
  input wire logic signed [7:0] remote_one_offset,
  input wire logic signed [7:0] remote_two_offset,
  output logic signed [RAW_W-1:0] local_temp,
  output logic signed [RAW_W-1:0] remote_one_temp,
  output logic signed [RAW_W-1:0] remote_two_temp,
  output logic temp_update,
  output logic busy,
  output logic low_power_hold
);
  import css_pkg::*;

  typedef struct packed {
    css_state_t state;
    // Configuration fields
    logic hold;
    logic [1:0] isel;
    logic [2:0] en;
    // Pass progress
    logic shot_pend;
    logic [1:0] chan;
    logic [31:0] timer;
    // Registered outputs
    logic start;
    logic update;
    logic [7:0] rdata;
    logic signed [RAW_W-1:0] t_local;
    logic signed [RAW_W-1:0] t_rem1;
    logic signed [RAW_W-1:0] t_rem2;
  } css_regs_t;

  css_regs_t s;
  css_regs_t next_s;

  // Lowest enabled channel at or above a start point; bit 2 flags found
  function automatic logic [2:0] css_pick(input logic [2:0] en, input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 2; i >= 0; i--)
    begin
      if (en[i] && (3'(i) >= from))
        res = {1'b1, 2'(i)};
    end
    return res;
  endfunction : css_pick

  // Offset in half degrees scaled to raw lsb and added
  function automatic logic signed [RAW_W-1:0] css_apply_offset(
    input logic signed [RAW_W-1:0] raw,
    input logic signed [7:0] ofs);
    logic signed [RAW_W+1:0] wide;
    wide = (RAW_W+2)'(raw) + ((RAW_W+2)'(ofs) <<< CSS_OFFSET_SHIFT);
    return wide[RAW_W-1:0];
  endfunction : css_apply_offset

  // Cycle count of the selected interval
  function automatic logic [31:0] css_limit(input logic [1:0] isel);
    case (isel)
      CSS_ISEL_SHORT: return INTERVAL_SHORT_CYC;
      CSS_ISEL_MID: return INTERVAL_MID_CYC;
      default: return INTERVAL_LONG_CYC;
    endcase
  endfunction : css_limit

  // Combinational helpers of the next-state logic
  logic [2:0] pick;
  logic signed [RAW_W-1:0] adj;
  logic shot_wr;

  // Accepted one-shot request; beats the clear at pass start
  assign shot_wr = reg_wr && (reg_addr == CSS_ADDR_ONE_SHOT) && s.hold;

  // Next state of registers and scheduler
  always_comb
  begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.update = 1'b0;
    pick = 3'h0;
    adj = '0;
    // Register writes; unassigned bits dropped
    if (reg_wr)
    begin
      case (reg_addr)
        CSS_ADDR_MAIN_CFG: next_s.hold = reg_wdata[CSS_HOLD_BIT];
        CSS_ADDR_INTERVAL: next_s.isel = reg_wdata[1:0];
        CSS_ADDR_CHAN_EN: next_s.en = reg_wdata[2:0];
        CSS_ADDR_ONE_SHOT:
        begin
          if (s.hold)
            next_s.shot_pend = 1'b1;
        end
        default: ;
      endcase
    end
    // Register reads, unmapped and one-shot read zero
    if (reg_rd)
    begin
      case (reg_addr)
        CSS_ADDR_MAIN_CFG: next_s.rdata = 8'(s.hold) << CSS_HOLD_BIT;
        CSS_ADDR_INTERVAL: next_s.rdata = {6'h00, s.isel};
        CSS_ADDR_CHAN_EN: next_s.rdata = {5'h00, s.en};
        default: next_s.rdata = 8'h00;
      endcase
    end
    case (s.state)
      CSS_IDLE:
      begin
        // Start a pass when running, or on a pending one-shot
        if (!s.hold || s.shot_pend)
        begin
          // A one-shot taken in this very cycle stays pending
          next_s.shot_pend = shot_wr;
          // Start cycle is the first cycle of the interval
          next_s.timer = 32'h1;
          pick = css_pick(s.en, 3'h0);
          if (pick[2])
          begin
            next_s.chan = pick[1:0];
            next_s.start = 1'b1;
            next_s.state = CSS_CONV;
          end
          else if (!s.hold && s.isel != CSS_ISEL_CONT)
            next_s.state = CSS_WAIT;
        end
      end
      CSS_CONV:
      begin
        next_s.timer = s.timer + 32'h1;
        if (conv_done)
        begin
          next_s.update = 1'b1;
          // Store the reading, remote ones offset corrected
          case (s.chan)
            CSS_CH_REMOTE_ONE:
            begin
              adj = css_apply_offset(conv_raw, remote_one_offset);
              next_s.t_rem1 = adj;
            end
            CSS_CH_REMOTE_TWO:
            begin
              adj = css_apply_offset(conv_raw, remote_two_offset);
              next_s.t_rem2 = adj;
            end
            default: next_s.t_local = conv_raw;
          endcase
          // Next enabled channel, skipping disabled ones
          pick = css_pick(s.en, {1'b0, s.chan} + 3'h1);
          if (pick[2])
          begin
            next_s.chan = pick[1:0];
            next_s.start = 1'b1;
          end
          else if (s.hold || s.isel == CSS_ISEL_CONT)
            next_s.state = CSS_IDLE;
          else
            next_s.state = CSS_WAIT;
        end
      end
      CSS_WAIT:
      begin
        // Idle to the end of the interval, measured from pass start
        next_s.timer = s.timer + 32'h1;
        if (s.hold)
          next_s.state = CSS_IDLE;
        else if (s.isel == CSS_ISEL_CONT || s.timer >= css_limit(s.isel) - 32'h1)
          next_s.state = CSS_IDLE;
      end
      default: next_s.state = CSS_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.state <= CSS_IDLE;
      s.hold <= CSS_MAIN_CFG_RST[CSS_HOLD_BIT];
      s.isel <= CSS_INTERVAL_RST[1:0];
      s.en <= CSS_CHAN_EN_RST[2:0];
    end
    else
      s <= next_s;
  end

  // Register bus read data
  assign reg_rdata = s.rdata;

  // Converter handshake
  assign conv_start = s.start;
  assign conv_channel = s.chan;

  // Stored readings and their update strobe
  assign local_temp = s.t_local;
  assign remote_one_temp = s.t_rem1;
  assign remote_two_temp = s.t_rem2;
  assign temp_update = s.update;

  // Status
  assign busy = (s.state == CSS_CONV);
  assign low_power_hold = s.hold;
endmodule : css_scheduler

// ==== verilog/css_pkg.sv ====
// Constants and types of the conversion scheduler configuration block
// Behaviour
// - Offset low bits weigh 2, 1, 0.5 degrees
// - Standby bit set: a pass already converting runs to its end, then convert only on one-shot
// - Interval select: continuous, 0.364 s, 1 s, 2.5 s
// - Convert enabled channels, then idle until interval
// - Disabled channels are skipped in the sequence
// - Timed intervals stay fixed despite skipped channels
// - Enable bits: remote two, remote one, local
// - Unassigned bits read zero, ignore writes
// - One-shot write in standby runs one pass
// - Offset added to raw remote result before storing
package css_pkg;
  // Register command bytes
  localparam logic [7:0] CSS_ADDR_MAIN_CFG = 8'h03;
  localparam logic [7:0] CSS_ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] CSS_ADDR_CHAN_EN = 8'h05;
  localparam logic [7:0] CSS_ADDR_ONE_SHOT = 8'h0f;
  // Field positions
  localparam int CSS_HOLD_BIT = 6;
  localparam int CSS_LOCAL_BIT = 0;
  localparam int CSS_REMOTE_ONE_BIT = 1;
  localparam int CSS_REMOTE_TWO_BIT = 2;
  // Values after reset
  localparam logic [7:0] CSS_MAIN_CFG_RST = 8'h00;
  localparam logic [7:0] CSS_INTERVAL_RST = 8'h02;
  localparam logic [7:0] CSS_CHAN_EN_RST = 8'h1f;
  // Channel numbers
  localparam logic [1:0] CSS_CH_LOCAL = 2'h0;
  localparam logic [1:0] CSS_CH_REMOTE_ONE = 2'h1;
  localparam logic [1:0] CSS_CH_REMOTE_TWO = 2'h2;
  // Interval select codes
  localparam logic [1:0] CSS_ISEL_CONT = 2'h0;
  localparam logic [1:0] CSS_ISEL_SHORT = 2'h1;
  localparam logic [1:0] CSS_ISEL_MID = 2'h2;
  // Interval times in us and clock rate in MHz
  localparam int CSS_INTERVAL_SHORT_US = 364000;
  localparam int CSS_INTERVAL_MID_US = 1000000;
  localparam int CSS_INTERVAL_LONG_US = 2500000;
  localparam int CSS_CLK_MHZ = 250;
  // Offset fraction: offset lsb is 0.5 C, raw lsb 0.125 C
  localparam int CSS_OFFSET_SHIFT = 2;
  // Scheduler states, Gray along idle, convert, wait
  typedef enum logic [1:0]
  {
    CSS_IDLE = 2'b00,
    CSS_CONV = 2'b01,
    CSS_WAIT = 2'b11
  } css_state_t;
endpackage : css_pkg

// ==== verilog/unused_placeholder_none.sv ====
// Intentionally empty design unit list marker
`timescale 1ns/1ps

// ==== tb/css_monitor.sv ====
// Assertion checker of the conversion scheduler
`timescale 1ns/1ps
module css_monitor #(parameter int RAW_W = 11) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_start,
  input wire logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic signed [RAW_W-1:0] conv_raw,
  input wire logic signed [7:0] remote_one_offset,
  input wire logic signed [RAW_W-1:0] remote_one_temp,
  input wire logic temp_update,
  input wire logic busy,
  input wire logic low_power_hold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Properties of bus and scheduler
  sequence s_done; conv_done && busy; endsequence
  sequence s_quiet; !busy && !$past(busy) && low_power_hold && !reg_wr && !$past(reg_wr);
  endsequence
  property p_upd; s_done |=> temp_update; endproperty
  property p_rem; temp_update && $past(conv_channel) == 2'h1 |->
    remote_one_temp == RAW_W'($past(conv_raw) + 4 * $past(remote_one_offset)); endproperty
  property p_hold; s_quiet |=> !conv_start; endproperty
  property p_cfg_wr; reg_wr && reg_addr == 8'h03 |=> low_power_hold == $past(reg_wdata[6]);
  endproperty
  property p_cfg_rd; reg_rd && !reg_wr && reg_addr == 8'h03 |=>
    reg_rdata == {1'b0, low_power_hold, 6'h00}; endproperty
  property p_os_rd; reg_rd && reg_addr == 8'h0f |=> reg_rdata == 8'h00; endproperty
  property p_chan; conv_start |-> busy && conv_channel != 2'h3; endproperty
  property p_pulse; conv_start |=> !conv_start; endproperty
  a_upd: assert property (p_upd) else $error("no update after done");
  a_rem: assert property (p_rem) else $error("offset sum wrong");
  a_hold: assert property (p_hold) else $error("start in standby");
  a_cfg_wr: assert property (p_cfg_wr) else $error("standby bit wrong");
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
  a_os_rd: assert property (p_os_rd) else $error("one-shot kept");
  a_chan: assert property (p_chan) else $error("bad channel");
  a_pulse: assert property (p_pulse) else $error("long start");
endmodule : css_monitor
bind css_scheduler css_monitor #(.RAW_W(RAW_W)) u_mon (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_done(conv_done), .conv_raw(conv_raw), .remote_one_offset(remote_one_offset),
  .remote_one_temp(remote_one_temp), .temp_update(temp_update), .busy(busy),
  .low_power_hold(low_power_hold));

// ==== tb/css_conv_model.sv ====
// Converter model answering start pulses
`timescale 1ns/1ps
module css_conv_model #(parameter logic [3:0] DLY = 4'h6) (
  input wire logic mclk,
  input wire logic conv_start,
  output logic conv_done,
  output logic signed [10:0] conv_raw
);
  logic [3:0] cnt = 4'h0;
  initial conv_done = 1'b0;
  initial conv_raw = 11'sh0;
  // Count down from each start, pulse done; raw moves every cycle
  always @(posedge mclk)
  begin
    conv_raw <= conv_raw + 11'sd37;
    conv_done <= (cnt == 4'h1);
    if (conv_start)
      cnt <= DLY;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
  end
endmodule : css_conv_model

// ==== tb/tb.sv ====
// Testbench of the conversion scheduler
`timescale 1ns/1ps
module tb;
  logic mclk, nrst, reg_wr, reg_rd, conv_done, temp_update, busy, hold, conv_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [1:0] conv_channel, pch;
  logic signed [10:0] conv_raw, lt, r1t, r2t, pexp;
  logic signed [7:0] ofs1, ofs2;
  int num_errors = 0, compares = 0, seed = 1570, nstart = 0, last_t = 0, per = 0;
  int chq[$];
  css_scheduler #(.INTERVAL_SHORT_CYC(200), .INTERVAL_MID_CYC(400), .INTERVAL_LONG_CYC(800))
    uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_raw(conv_raw),
    .remote_one_offset(ofs1), .remote_two_offset(ofs2), .local_temp(lt),
    .remote_one_temp(r1t), .remote_two_temp(r2t), .temp_update(temp_update), .busy(busy),
    .low_power_hold(hold));
  css_conv_model conv (.mclk(mclk), .conv_start(conv_start), .conv_done(conv_done),
    .conv_raw(conv_raw));
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check({3'h0, reg_rdata}, {3'h0, e});
  endtask : rd_chk
  task automatic wrap_up;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Random offsets
  always @(negedge mclk)
  begin
    ofs1 = 8'($random(seed));
    ofs2 = 8'($random(seed));
  end
  // Reference model of stored readings, start count, order and period
  always @(posedge mclk)
  begin
    if (temp_update)
      check(pch == 2'h0 ? lt : pch == 2'h1 ? r1t : r2t, pexp);
    if (conv_done && busy)
    begin
      pch = conv_channel;
      pexp = conv_raw + 11'(4 * (pch == 2'h1 ? ofs1 : pch == 2'h2 ? ofs2 : 8'sh0));
    end
    if (conv_start)
    begin
      nstart++;
      chq.push_back(int'(conv_channel));
      if (conv_channel == 2'h0)
      begin
        per = int'($time / 4) - last_t;
        last_t = int'($time / 4);
      end
    end
  end
  initial
  begin
    #160000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h05, 8'h07);
    repeat (8)
    begin
      d = 8'($random(seed));
      wr(8'h04, d);
      rd_chk(8'h04, d & 8'h03);
      wr(8'h05, d);
      rd_chk(8'h05, d & 8'h07);
    end
    rd_chk(8'h0f, 8'h00);
    for (int i = 1; i < 4; i++)
    begin
      wr(8'h05, 8'h05);
      wr(8'h04, 8'(i));
      wr(8'h0f, d);
      repeat (2000) @(negedge mclk);
      check(11'(per), 11'(100 << i));
    end
    wr(8'h04, 8'h00);
    repeat (100) @(negedge mclk);
    chq.delete();
    repeat (200) @(negedge mclk);
    for (int k = 0; k + 1 < chq.size(); k++)
      check(11'(chq[k + 1]), 11'(2 - chq[k]));
    wr(8'h03, 8'hff);
    rd_chk(8'h03, 8'h40);
    check({10'h000, hold}, 11'h001);
    repeat (100) @(negedge mclk);
    nstart = 0;
    repeat (300) @(negedge mclk);
    check(11'(nstart), 11'h0);
    wr(8'h0f, d);
    repeat (100) @(negedge mclk);
    check(11'(nstart), 11'h2);
    // Reset in standby after the one-shot pass restores the configuration
    nrst = 1'b0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h05, 8'h07);
    wrap_up();
  end
endmodule : tb
